// *** pkg/spi_link_pkg.sv ***
// Shared constants for the port manager serial link (both ends)
package spi_link_pkg;
  localparam int MCLK_HZ = 40_000_000;
  localparam int LINK_HZ = 1_000_000;
  localparam int HALF_CYC = MCLK_HZ / (2 * LINK_HZ);
  localparam int LINK_CYC = 2 * HALF_CYC;
  localparam int CS_SETUP_NS = 340;
  localparam int CS_HOLD_NS = 340;
  localparam int CS_SETUP_CYC =
    (CS_SETUP_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CS_HOLD_CYC =
    (CS_HOLD_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;
  localparam int BYTE_GAP_LINK = 1;
  localparam int FRAME_GAP_LINK = 2;
  localparam int BYTE_GAP_CYC = BYTE_GAP_LINK * LINK_CYC;
  localparam int FRAME_GAP_CYC = FRAME_GAP_LINK * LINK_CYC;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int ID_W = 4;
  localparam int DIR_BIT = 0;
  localparam int ID_LSB = 1;
  localparam int ID_MSB = 4;
  localparam int PFX_LSB = 5;
  localparam int PFX_MSB = 7;
  localparam logic [2:0] PFX_UNICAST = 3'h0;
  localparam logic [2:0] PFX_BCAST = 3'h1;
  localparam logic [ID_W-1:0] BCAST_ID = 4'h0;
  localparam logic [ID_W-1:0] MAX_ID = 4'hb;
  localparam logic DIR_READ = 1'b0;
  localparam logic DIR_WRITE = 1'b1;
  localparam logic [BYTE_W-1:0] DUMMY_BYTE = 8'h00;
endpackage

// *** pkg/spi_link_if.sv ***
// Serial link between the controller and one or more port managers
interface spi_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso_d;
  logic miso_oe_n;
  logic miso;

  // Pulled up while no device drives the line
  assign miso = miso_oe_n ? 1'b1 : miso_d;

  modport dev (
    input  sck,
    input  cs_n,
    input  mosi,
    output miso_d,
    output miso_oe_n
  );

  modport host (
    output sck,
    output cs_n,
    output mosi,
    input  miso
  );
endinterface

// *** rtl/port_mgr_link_slave.sv ***
// Device end: serial slave giving access to 16-bit internal registers
module port_mgr_link_slave (
  input  wire logic                              mclk_i,
  input  wire logic                              rst_n_i,
  spi_link_if.dev                                link,
  input  wire logic [spi_link_pkg::ID_W-1:0]     identity_strap_pins_i,
  output logic [spi_link_pkg::BYTE_W-1:0]        reg_addr_o,
  output logic [spi_link_pkg::WORD_W-1:0]        reg_wdata_o,
  output logic                                   reg_wr_o,
  output logic                                   reg_bcast_o,
  output logic                                   reg_rd_o,
  input  wire logic [spi_link_pkg::WORD_W-1:0]   reg_rdata_i
);
  import spi_link_pkg::*;

  typedef enum logic [2:0] {
    ST_CTRL, ST_ADDR, ST_COUNT, ST_HI, ST_LO, ST_SKIP
  } dev_state_type;

  // Link clock domain
  logic [2:0]        bit_cnt_r;
  logic [BYTE_W-1:0] in_sr_r;
  logic [BYTE_W-1:0] byte_r;
  logic              byte_tgl_r;

  // Oscillator domain
  logic [2:0]        sck_s_r;
  logic [1:0]        cs_s_r;
  logic [2:0]        tgl_s_r;
  logic [ID_W-1:0]   id_s1_r;
  logic [ID_W-1:0]   id_s2_r;
  dev_state_type     state_r;
  logic              is_rd_r;
  logic              bcast_r;
  logic [BYTE_W-1:0] left_r;
  logic [BYTE_W-1:0] addr_r;
  logic [BYTE_W-1:0] hi_r;
  logic [WORD_W-1:0] wdata_r;
  logic              wr_r;
  logic              rd_r;
  logic              load_r;
  logic [WORD_W-1:0] tx_r;
  logic [WORD_W-1:0] word_r;
  logic              pend_r;
  logic              armed_r;
  logic [3:0]        shifts_r;
  logic              miso_r;
  logic              oe_n_r;

  logic              byte_ev;
  logic              sck_rise;
  logic              sck_fall;
  logic              selected;
  logic [BYTE_W-1:0] rx;
  logic              uni_hit;
  logic              bc_hit;

  // Bits are taken on the rising link clock edge; the select line clears
  // the bit position so every frame starts byte aligned.
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      bit_cnt_r <= 3'h0;
      in_sr_r   <= 8'h00;
    end else begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      in_sr_r   <= {in_sr_r[BYTE_W-2:0], link.mosi};
    end
  end

  // A finished byte is held still for the whole next byte, so the toggle
  // alone is the crossing event and the byte is read as quasi-static.
  always_ff @(posedge link.sck or negedge rst_n_i) begin
    if (!rst_n_i) begin
      byte_r     <= 8'h00;
      byte_tgl_r <= 1'b0;
    end else if (!link.cs_n && bit_cnt_r == 3'h7) begin
      byte_r     <= {in_sr_r[BYTE_W-2:0], link.mosi};
      byte_tgl_r <= ~byte_tgl_r;
    end
  end

  // Everything below runs on the internal oscillator
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_s_r <= 3'h0;
      cs_s_r  <= 2'h3;
      tgl_s_r <= 3'h0;
      id_s1_r <= 4'h0;
      id_s2_r <= 4'h0;
    end else begin
      sck_s_r <= {sck_s_r[1:0], link.sck};
      cs_s_r  <= {cs_s_r[0], link.cs_n};
      tgl_s_r <= {tgl_s_r[1:0], byte_tgl_r};
      id_s1_r <= identity_strap_pins_i;
      id_s2_r <= id_s1_r;
    end
  end

  assign byte_ev  = tgl_s_r[2] ^ tgl_s_r[1];
  assign sck_rise = sck_s_r[1] & ~sck_s_r[2];
  assign sck_fall = ~sck_s_r[1] & sck_s_r[2];
  assign selected = ~cs_s_r[1];
  assign rx       = byte_r;
  assign uni_hit  = rx[PFX_MSB:PFX_LSB] == PFX_UNICAST &&
                    rx[ID_MSB:ID_LSB] == id_s2_r;
  assign bc_hit   = rx[PFX_MSB:PFX_LSB] == PFX_BCAST &&
                    rx[ID_MSB:ID_LSB] == BCAST_ID &&
                    rx[DIR_BIT] == DIR_WRITE;

  // Packet walker; a deselect always returns it to the control byte
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_CTRL;
      is_rd_r <= 1'b0;
      bcast_r <= 1'b0;
      left_r  <= 8'h00;
      hi_r    <= 8'h00;
    end else if (!selected) begin
      state_r <= ST_CTRL;
      is_rd_r <= 1'b0;
      bcast_r <= 1'b0;
    end else if (byte_ev) begin
      unique case (state_r)
        ST_CTRL: begin
          if (uni_hit) begin
            is_rd_r <= rx[DIR_BIT] == DIR_READ;
            state_r <= ST_ADDR;
          end else if (bc_hit) begin
            bcast_r <= 1'b1;
            state_r <= ST_ADDR;
          end else begin
            // Foreign identity or broadcast read: stay silent
            state_r <= ST_SKIP;
          end
        end
        ST_ADDR: state_r <= is_rd_r ? ST_COUNT : ST_HI;
        ST_COUNT: begin
          left_r  <= rx;
          state_r <= (rx == 8'h00) ? ST_SKIP : ST_HI;
        end
        ST_HI: begin
          hi_r    <= rx;
          state_r <= ST_LO;
        end
        ST_LO: begin
          if (is_rd_r) begin
            left_r  <= left_r - 8'h01;
            state_r <= (left_r == 8'h01) ? ST_SKIP : ST_HI;
          end else begin
            state_r <= ST_HI;
          end
        end
        ST_SKIP: state_r <= ST_SKIP;
      endcase
    end
  end

  // Register address: loaded from the packet, stepped after each access
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_r <= 8'h00;
    end else if (byte_ev && selected && state_r == ST_ADDR) begin
      addr_r <= rx;
    end else if (wr_r || load_r) begin
      addr_r <= addr_r + 8'h01;
    end
  end

  // Register access strobes
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_r    <= 1'b0;
      rd_r    <= 1'b0;
      load_r  <= 1'b0;
      wdata_r <= 16'h0000;
    end else begin
      wr_r   <= selected && byte_ev && state_r == ST_LO && !is_rd_r;
      rd_r   <= selected && byte_ev && is_rd_r &&
                ((state_r == ST_COUNT && rx != 8'h00) ||
                 (state_r == ST_LO && left_r != 8'h01));
      load_r <= rd_r;
      if (selected && byte_ev && state_r == ST_LO && !is_rd_r) begin
        wdata_r <= {hi_r, rx};
      end
    end
  end

  // Read word shifter. A fall only shifts after a rise was seen since the
  // load, and at most fifteen times, so late falls never eat a bit. A word
  // fetched while the link clock is high waits for the fall, so the bit
  // the controller samples is not disturbed inside its hold window.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_r     <= 16'h0000;
      word_r   <= 16'h0000;
      pend_r   <= 1'b0;
      armed_r  <= 1'b0;
      shifts_r <= 4'h0;
    end else if (load_r && sck_s_r[1]) begin
      word_r   <= reg_rdata_i;
      pend_r   <= 1'b1;
    end else if (load_r || (sck_fall && pend_r)) begin
      tx_r     <= load_r ? reg_rdata_i : word_r;
      pend_r   <= 1'b0;
      armed_r  <= 1'b0;
      shifts_r <= 4'h0;
    end else if (sck_rise) begin
      armed_r <= 1'b1;
    end else if (sck_fall && armed_r && shifts_r != 4'hf) begin
      tx_r     <= {tx_r[WORD_W-2:0], 1'b0};
      shifts_r <= shifts_r + 4'h1;
    end
  end

  // Pin drive: only while selected for a read of this device; release
  // lands a few oscillator cycles after the select rises.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      miso_r <= 1'b1;
      oe_n_r <= 1'b1;
    end else begin
      miso_r <= tx_r[WORD_W-1];
      oe_n_r <= !(selected && is_rd_r);
    end
  end

  assign link.miso_d    = miso_r;
  assign link.miso_oe_n = oe_n_r;
  assign reg_addr_o     = addr_r;
  assign reg_wdata_o    = wdata_r;
  assign reg_wr_o       = wr_r;
  assign reg_bcast_o    = bcast_r;
  assign reg_rd_o       = rd_r;
endmodule

// *** rtl/port_mgr_link_master.sv ***
// Controller end: frames register reads and writes onto the serial link
module port_mgr_link_master (
  input  wire logic                              mclk_i,
  input  wire logic                              rst_n_i,
  spi_link_if.host                               link,
  input  wire logic                              start_i,
  output logic                                   ready_o,
  input  wire logic [spi_link_pkg::ID_W-1:0]     dev_id_i,
  input  wire logic                              bcast_i,
  input  wire logic                              write_i,
  input  wire logic [spi_link_pkg::BYTE_W-1:0]   addr_i,
  input  wire logic [spi_link_pkg::BYTE_W-1:0]   count_i,
  input  wire logic [spi_link_pkg::WORD_W-1:0]   wdata_i,
  output logic [spi_link_pkg::WORD_W-1:0]        rdata_o,
  output logic                                   rdata_valid_o,
  output logic                                   done_o
);
  import spi_link_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE, H_SETUP, H_BIT, H_GAP, H_HOLD, H_QUIET
  } host_state_type;

  host_state_type    state_r;
  logic [7:0]        tmr_r;
  logic [2:0]        bitn_r;
  logic [9:0]        idx_r;
  logic [9:0]        last_r;
  logic              wr_r;
  logic              bc_r;
  logic [BYTE_W-1:0] ctrl_r;
  logic [BYTE_W-1:0] addr_r;
  logic [BYTE_W-1:0] cnt_r;
  logic [WORD_W-1:0] wd_r;
  logic [BYTE_W-1:0] tx_r;
  logic [BYTE_W-1:0] rx_r;
  logic [BYTE_W-1:0] hi_r;
  logic [1:0]        miso_s_r;
  logic              sck_r;
  logic              cs_n_r;
  logic [BYTE_W-1:0] next_byte;
  logic [BYTE_W-1:0] rx_full;
  logic [9:0]        data_idx;

  always_comb begin
    data_idx = idx_r - 10'd3;
    unique case (idx_r)
      10'd0: next_byte = ctrl_r;
      10'd1: next_byte = addr_r;
      10'd2: next_byte = wr_r ? wd_r[15:8] : cnt_r;
      10'd3: next_byte = wr_r ? wd_r[7:0] : DUMMY_BYTE;
      default: next_byte = DUMMY_BYTE;
    endcase
  end

  assign rx_full = {rx_r[BYTE_W-2:0], miso_s_r[1]};

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      miso_s_r <= 2'h3;
    end else begin
      miso_s_r <= {miso_s_r[0], link.miso};
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= H_IDLE;
      tmr_r   <= 8'h00;
      bitn_r  <= 3'h0;
      idx_r   <= 10'h000;
      last_r  <= 10'h000;
      wr_r    <= 1'b0;
      bc_r    <= 1'b0;
      ctrl_r  <= 8'h00;
      addr_r  <= 8'h00;
      cnt_r   <= 8'h00;
      wd_r    <= 16'h0000;
      tx_r    <= 8'h00;
      rx_r    <= 8'h00;
      hi_r    <= 8'h00;
      sck_r   <= 1'b0;
      cs_n_r  <= 1'b1;
      rdata_o <= 16'h0000;
      rdata_valid_o <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      rdata_valid_o <= 1'b0;
      done_o        <= 1'b0;
      unique case (state_r)
        H_IDLE: begin
          if (start_i) begin
            wr_r   <= write_i;
            bc_r   <= bcast_i;
            ctrl_r <= bcast_i ? {PFX_BCAST, BCAST_ID, write_i}
                              : {PFX_UNICAST, dev_id_i, write_i};
            addr_r <= addr_i;
            cnt_r  <= count_i;
            wd_r   <= wdata_i;
            last_r <= write_i ? 10'd3 : 10'd2 + {1'b0, count_i, 1'b0};
            idx_r  <= 10'h000;
            cs_n_r <= 1'b0;
            tmr_r  <= 8'(CS_SETUP_CYC);
            state_r <= H_SETUP;
          end
        end
        H_SETUP, H_GAP: begin
          if (tmr_r != 8'h00) begin
            tmr_r <= tmr_r - 8'h01;
          end else begin
            tx_r    <= next_byte;
            bitn_r  <= 3'h0;
            tmr_r   <= 8'(HALF_CYC - 1);
            state_r <= H_BIT;
          end
        end
        H_BIT: begin
          if (tmr_r != 8'h00) begin
            tmr_r <= tmr_r - 8'h01;
          end else if (!sck_r) begin
            sck_r <= 1'b1;
            rx_r  <= rx_full;
            tmr_r <= 8'(HALF_CYC - 1);
          end else begin
            sck_r  <= 1'b0;
            tx_r   <= {tx_r[BYTE_W-2:0], 1'b0};
            bitn_r <= bitn_r + 3'h1;
            tmr_r  <= 8'(HALF_CYC - 1);
            if (bitn_r == 3'h7) begin
              idx_r <= idx_r + 10'h001;
              if (!wr_r && idx_r >= 10'd3) begin
                if (!data_idx[0]) begin
                  hi_r <= rx_r;
                end else if (!bc_r) begin
                  rdata_o       <= {hi_r, rx_r};
                  rdata_valid_o <= 1'b1;
                end
              end
              if (idx_r == last_r) begin
                tmr_r   <= 8'(CS_HOLD_CYC);
                state_r <= H_HOLD;
              end else begin
                tmr_r   <= 8'(BYTE_GAP_CYC);
                state_r <= H_GAP;
              end
            end
          end
        end
        H_HOLD: begin
          if (tmr_r != 8'h00) begin
            tmr_r <= tmr_r - 8'h01;
          end else begin
            cs_n_r  <= 1'b1;
            tmr_r   <= 8'(FRAME_GAP_CYC);
            state_r <= H_QUIET;
          end
        end
        H_QUIET: begin
          // Covers the frame gap and the least select-high time
          if (tmr_r != 8'h00) begin
            tmr_r <= tmr_r - 8'h01;
          end else begin
            done_o  <= 1'b1;
            state_r <= H_IDLE;
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  // Registered so the handshake output comes straight from a flop
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_o <= 1'b1;
    end else begin
      ready_o <= state_r == H_IDLE && !start_i;
    end
  end

  assign link.sck  = sck_r;
  assign link.cs_n = cs_n_r;
  assign link.mosi = tx_r[BYTE_W-1];
endmodule

// *** sim/spi_link_properties.sv ***
// Timing and framing checks on the controller to device link
module spi_link_properties
  import spi_link_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_d,
  input wire logic miso_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // Release limit of 700 ns counted in checker clock cycles
  localparam int REL_CYC = 700 * (MCLK_HZ / 1_000_000) / 1000;
  localparam int GAP_MIN = LINK_CYC + HALF_CYC - 2;

  logic       sck_q;
  logic       seen;
  logic [7:0] rise_cnt;
  logic [7:0] low_cnt;
  logic [7:0] since_rise;
  logic [7:0] cs_hi_cnt;
  wire        sck_up = sck && !sck_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_q      <= 1'b0;
      seen       <= 1'b0;
      rise_cnt   <= 8'h00;
      low_cnt    <= 8'h00;
      since_rise <= 8'h00;
      cs_hi_cnt  <= 8'h00;
    end else begin
      sck_q      <= sck;
      seen       <= seen || (cs_n && rise_cnt != 8'h00);
      rise_cnt   <= cs_n ? 8'h00 : rise_cnt + {7'h00, sck_up};
      low_cnt    <= sck ? 8'h00 : low_cnt + {7'h00, low_cnt != 8'hff};
      since_rise <= sck_up ? 8'h00
                           : since_rise + {7'h00, since_rise != 8'hff};
      cs_hi_cnt  <= !cs_n ? 8'h00
                          : cs_hi_cnt + {7'h00, cs_hi_cnt != 8'hff};
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  chk_oe_release: assert property (
    $rose(cs_n) |-> ##[0:REL_CYC] miso_oe_n)
    else $error("output not released after deselect");
  chk_drive_selected: assert property (
    cs_hi_cnt > REL_CYC |-> miso_oe_n)
    else $error("output driven while deselected");
  chk_sck_framed: assert property (
    cs_n |-> !sck)
    else $error("link clock runs outside a frame");
  chk_mosi_stable: assert property (
    sck |-> $stable(mosi))
    else $error("data out changed while clock high");
  chk_miso_stable: assert property (
    $rose(sck) && !miso_oe_n && !$past(miso_oe_n, 8)
    |-> miso_d == $past(miso_d, 8) ##1 $stable(miso_d) [*7])
    else $error("read data not stable around clock rise");
  chk_byte_gap: assert property (
    sck_up && rise_cnt != 8'h00 && rise_cnt[2:0] == 3'h0
    |-> low_cnt >= GAP_MIN)
    else $error("no idle period between bytes");
  chk_frame_gap: assert property (
    sck_up && rise_cnt == 8'h00 && seen |-> since_rise >= FRAME_GAP_CYC)
    else $error("frames too close");
  chk_cs_width: assert property (
    $fell(cs_n) && seen |-> cs_hi_cnt >= LINK_CYC)
    else $error("select high too short");
  chk_whole_bytes: assert property (
    $rose(cs_n) |-> rise_cnt[2:0] == 3'h0 && rise_cnt >= 8'h10)
    else $error("frame not whole bytes");

  cover property ($fell(miso_oe_n));
  cover property ($rose(cs_n) && rise_cnt == 8'h38);
  cover property ($rose(cs_n) && rise_cnt == 8'h18);
  cover property ($fell(cs_n) && seen);
endmodule

// *** sim/poe_port_manager_spi_slave_tb_top.sv ***
// Bench: controller end and one device end joined on one link
`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin \
  n_mismatch++; $display("unexpected at %0t: %s", $time, m); end end
module poe_port_manager_spi_slave_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import spi_link_pkg::*;

  logic        mclk = 1'b0;
  logic        dev_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        start = 1'b0;
  logic        bcast = 1'b0;
  logic        write = 1'b0;
  logic [3:0]  dev_id = 4'h0;
  logic [3:0]  strap = MAX_ID;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  count = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic        ready, done, rvalid, reg_wr, reg_bcast, reg_rd;
  logic [15:0] rdata, reg_wdata;
  logic [7:0]  reg_addr;
  logic [15:0] mem [256];
  logic [15:0] rq [$];
  logic [7:0]  wa;
  logic [15:0] wd;
  logic        bc_seen, drv;
  int          n_mismatch = 0;
  int          compares = 0;
  int          n_wr, n_rd;

  // Device oscillator is a separate, faster clock with drifting phase
  always #12.5 mclk = ~mclk;
  always #6 dev_clk = ~dev_clk;

  spi_link_if link_bus ();

  port_mgr_link_master u_port_mgr_link_master (.mclk_i(mclk),
    .rst_n_i(rst_n), .link(link_bus), .start_i(start), .ready_o(ready),
    .dev_id_i(dev_id), .bcast_i(bcast), .write_i(write), .addr_i(addr),
    .count_i(count), .wdata_i(wdata), .rdata_o(rdata),
    .rdata_valid_o(rvalid), .done_o(done));

  port_mgr_link_slave u_port_mgr_link_slave (.mclk_i(dev_clk),
    .rst_n_i(rst_n), .link(link_bus), .identity_strap_pins_i(strap),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr),
    .reg_bcast_o(reg_bcast), .reg_rd_o(reg_rd), .reg_rdata_i(mem[reg_addr]));

  spi_link_properties u_spi_link_properties (.mclk_i(mclk),
    .rst_n_i(rst_n), .sck(link_bus.sck), .cs_n(link_bus.cs_n),
    .mosi(link_bus.mosi), .miso_d(link_bus.miso_d),
    .miso_oe_n(link_bus.miso_oe_n));

  always @(posedge dev_clk) begin
    if (reg_wr) begin
      mem[reg_addr] <= reg_wdata;
      n_wr++;
      wa = reg_addr;
      wd = reg_wdata;
      bc_seen = reg_bcast;
    end
    if (reg_rd) n_rd++;
  end

  always @(posedge mclk) begin
    if (rvalid) rq.push_back(rdata);
    if (link_bus.miso_oe_n !== 1'b1) drv = 1'b1;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic op(input logic [3:0] id, input logic bc, wr,
                    input logic [7:0] a, n, input logic [15:0] d);
    int k;
    @(negedge mclk);
    {n_wr, n_rd, drv, bc_seen} = '0;
    rq.delete();
    {dev_id, bcast, write, addr, count, wdata} = {id, bc, wr, a, n, d};
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    `CHK(ready, 1'b0, "ready while frame runs")
    for (k = 0; k < 20000 && done !== 1'b1; k++) @(negedge mclk);
    if (done !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: frame never ended", $time);
      close_out();
    end
    @(negedge mclk);
    `CHK(ready, 1'b1, "not ready after frame")
  endtask

  task automatic t_strap();
    @(negedge mclk);
    strap = 4'h3;
    op(4'h3, 1'b0, 1'b1, 8'h30, 8'h00, 16'h0f0f);
    `CHK(n_wr, 1, "new identity ignored")
    `CHK(mem[8'h30], 16'h0f0f, "new identity write")
    op(MAX_ID, 1'b0, 1'b1, 8'h30, 8'h00, 16'hf0f0);
    `CHK(n_wr, 0, "old identity still answered")
    `CHK(mem[8'h30], 16'h0f0f, "old identity wrote")
    strap = MAX_ID;
    $display("test strap done");
  endtask

  task automatic t_zero_count();
    op(MAX_ID, 1'b0, 1'b0, 8'h10, 8'h00, 16'h0000);
    `CHK(n_rd, 0, "zero count read strobed")
    `CHK(rq.size(), 0, "zero count returned words")
    $display("test zero_count done");
  endtask

  task automatic t_write_read();
    op(MAX_ID, 1'b0, 1'b1, 8'h10, 8'h00, 16'hbeef);
    `CHK(n_wr, 1, "write count")
    `CHK(wa, 8'h10, "write address")
    `CHK(wd, 16'hbeef, "write word")
    `CHK(bc_seen, 1'b0, "unicast flagged broadcast")
    op(MAX_ID, 1'b0, 1'b0, 8'h10, 8'h02, 16'h0000);
    `CHK(rq.size(), 2, "read word count")
    `CHK(rq[0], 16'hbeef, "first word")
    `CHK(rq[1], 16'h1111 ^ 16'ha5c3, "second word")
    `CHK(n_rd, 2, "read strobes")
    `CHK(drv, 1'b1, "read never drove output")
    $display("test write_read done");
  endtask

  task automatic t_foreign();
    op(4'h0, 1'b0, 1'b1, 8'h10, 8'h00, 16'h1234);
    op(4'h0, 1'b0, 1'b0, 8'h10, 8'h01, 16'h0000);
    `CHK(n_wr + n_rd, 0, "foreign frame acted on")
    `CHK(drv, 1'b0, "foreign read drove output")
    `CHK(rq[0], 16'hffff, "released line not high")
    `CHK(mem[8'h10], 16'hbeef, "register overwritten")
    $display("test foreign done");
  endtask

  task automatic t_bcast();
    op(4'h0, 1'b1, 1'b1, 8'h20, 8'h00, 16'h5a5a);
    `CHK(n_wr, 1, "broadcast write count")
    `CHK(mem[8'h20], 16'h5a5a, "broadcast write data")
    `CHK(bc_seen, 1'b1, "broadcast flag")
    op(4'h0, 1'b1, 1'b0, 8'h20, 8'h01, 16'h0000);
    `CHK(n_rd + n_wr, 0, "broadcast read acted")
    `CHK(rq.size(), 0, "broadcast read returned data")
    `CHK(drv, 1'b0, "broadcast read drove output")
    $display("test bcast done");
  endtask

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'(i * 16'h0101) ^ 16'ha5c3;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    t_write_read();
    t_foreign();
    t_bcast();
    t_strap();
    t_zero_count();
    close_out();
  end
endmodule
